// ===== core/csfl_pkg.sv
package csfl_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // register addresses
  localparam logic [7:0] REG_MODE     = 8'h12;
  localparam logic [7:0] REG_STATUS   = 8'h13;
  localparam logic [7:0] REG_CHGV     = 8'h15;
  localparam logic [7:0] REG_INT_STAT = 8'h30;
  localparam logic [7:0] REG_INT_MASK = 8'h31;

  // reset values
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] CHGV_RST = 16'h0000;
  localparam logic [2:0]  INTM_RST = 3'h0;

  // mode register fields
  localparam int MODE_LEARN_BIT = 4;
  localparam int MODE_DEP_LSB   = 9;
  localparam int MODE_DEP_W     = 3;

  // status register flag positions
  localparam int STAT_DEPLETED = 11;
  localparam int STAT_RANGE    = 12;
  localparam int STAT_BAT_HI   = 13;
  localparam int STAT_BAT_PRES = 14;
  localparam int STAT_AD_PRES  = 15;
  localparam int STAT_FLAG_W   = 5;

  // interrupt status / mask bits
  localparam int INT_W        = 3;
  localparam int INT_FLAG_CHG = 0;
  localparam int INT_RANGE    = 1;
  localparam int INT_BYPASS   = 2;

  // charge-voltage settings in mV
  localparam logic [15:0] V_WAKE   = 16'h2328;
  localparam logic [15:0] V_LO_MIN = 16'h2ee0;
  localparam logic [15:0] V_LO_MAX = 16'h3840;
  localparam logic [15:0] V_HI_MIN = 16'h3e80;
  localparam logic [15:0] V_HI_MAX = 16'h4b00;
  // converter step: low bits dropped when rounding down
  localparam logic [15:0] V_STEP_MASK = 16'h000f;

  // depleted threshold per cell: base plus code times step, mV
  localparam logic [15:0] DEP_BASE_MV = 16'h0a8c;
  localparam logic [15:0] DEP_STEP_MV = 16'h0064;

  // bypass switch margins in mV
  localparam logic [16:0] BYP_TRIP_MV = 17'h00096;
  localparam logic [16:0] BYP_HYST_MV = 17'h00064;

  // timing
  localparam int CLK_KHZ     = 250000;
  localparam int DEGLITCH_MS = 8;
  localparam int ALERT_MS    = 8;
  localparam int DEGLITCH_CYC_DEF = DEGLITCH_MS * CLK_KHZ;
  localparam int ALERT_CYC_DEF    = ALERT_MS * CLK_KHZ;
  localparam int CNT_W = 22;

endpackage

// ===== core/csfl_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser, one lane per pin
module csfl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : gLane
      logic meta_q;
      logic sync_q;
      // first flop feeds only the second
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= asyncIn[i];
          sync_q <= meta_q;
        end
      end
      assign syncOut[i] = sync_q;
    end
  endgenerate

endmodule

`default_nettype wire

// ===== core/csfl_top.sv
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - the depleted flag (status bit 11) is high while battery voltage is below the threshold picked by mode bits 11..9.
// - the per-cell depleted threshold is multiplied by three cells in the lower band and four in the upper band.
// - in learn cycle with adapter present, a depleted battery turns the battery switch off and the adapter switch on.
// - the out-of-range flag (status bit 12) is high whenever the charge-voltage setting is outside the valid range.
// - valid settings are 9 V and the two bands, and values between converter steps round down.
// - a setting above the maximum keeps charging enabled and clamps the target to the maximum.
// - a setting below 12 V other than 9 V, or in the gap between bands, disables charging, flags and alarms the host.
// - the 9 V wake-up code makes the charger regulate to 9 V.
// - status bit 13 is high while the battery voltage exceeds the adapter voltage.
// - the bypass switch drops at once when input is under battery plus 150 mV and returns after 8 ms and 100 mV hysteresis.
// - the battery-present flag (bit 14) follows the thermistor battery-detect comparator.
// - charging stops at once, without the host, when no battery is detected.
// - the adapter-present flag (bit 15) follows the 2.4 V adapter-detect comparator.
// - charging and the five-volt reference stay off until the adapter is detected.
// - serial communication is enabled only once adapter detect is above 1.2 V and supply above 6.5 V.
// - the first status flag change starts the alert timer; the alert output rises 6 to 10 ms after it.
module csfl_top
  import csfl_pkg::*;
#(
  parameter int DEGLITCH_CYC = csfl_pkg::DEGLITCH_CYC_DEF,
  parameter int ALERT_CYC    = csfl_pkg::ALERT_CYC_DEF
) (
  input  wire logic                          mclk,
  input  wire logic                          reset_n,
  input  wire logic [csfl_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [csfl_pkg::DATA_W-1:0]   regWrData,
  input  wire logic                          regWrStb,
  input  wire logic                          regRdStb,
  output logic      [csfl_pkg::DATA_W-1:0]   regRdData,
  input  wire logic [15:0]                   batteryMv,
  input  wire logic [15:0]                   adapterMv,
  input  wire logic                          adapterDetectPin,
  input  wire logic                          adapterDetectLowPin,
  input  wire logic                          supplyOkPin,
  input  wire logic                          thermistorBelowPin,
  output logic                               batterySwitchDrive,
  output logic                               adapterSwitchDrive,
  output logic                               bypassSwitchDrive,
  output logic                               chargeEnable,
  output logic      [15:0]                   regulationTargetMv,
  output logic                               fiveVoltRefEnable,
  output logic                               commEnable,
  output logic                               alert,
  output logic                               irq
);

  import csfl_pkg::*;

  // synchronised comparator pins
  logic [3:0] pinSync;
  logic       adapterPresent;
  logic       adapterLowOk;
  logic       supplyOk;
  logic       batteryPresent;

  // register state
  logic [15:0]          mode_q;
  logic [15:0]          chgV_q;
  logic [INT_W-1:0]     intStat_q;
  logic [INT_W-1:0]     intStat_d;
  logic [INT_W-1:0]     intMask_q;
  logic [DATA_W-1:0]    rdData_q;
  logic                 commEn_q;

  // flag state
  logic [STAT_FLAG_W-1:0] flags_q;
  logic [STAT_FLAG_W-1:0] flags_d;
  logic [15:0]            statusWord;

  // charge-voltage evaluation
  logic        isWake;
  logic        inLoBand;
  logic        inHiBand;
  logic        aboveMax;
  logic        rangeBad;
  logic        rangeBlocks;
  logic        fourCells;
  logic [15:0] roundedV;
  logic [15:0] target_d;

  // depleted threshold
  logic [MODE_DEP_W-1:0] depCode;
  logic [15:0]           perCellMv;
  logic [15:0]           depThreshMv;
  logic                  depleted;
  logic                  learnCycle;

  // bypass switch
  logic [16:0]      battPlusTrip;
  logic [16:0]      battPlusRecover;
  logic             bypassTrip;
  logic             bypassRecover;
  logic             bypassOn_q;
  logic [CNT_W-1:0] deglitchCnt_q;

  // outputs and alert timer
  logic             battDrv_q;
  logic             adDrv_q;
  logic             chgEn_q;
  logic [15:0]      target_q;
  logic             vrefEn_q;
  logic             alertPend_q;
  logic [CNT_W-1:0] alertCnt_q;
  logic             alert_q;
  logic             rangeBadPrev_q;

  // bus qualifiers
  logic wrOk;
  logic rdOk;
  logic intClrWr;

  csfl_sync #(
    .WIDTH(4)
  ) uSync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .asyncIn ({thermistorBelowPin, supplyOkPin, adapterDetectLowPin, adapterDetectPin}),
    .syncOut (pinSync)
  );

  assign adapterPresent = pinSync[0];
  assign adapterLowOk   = pinSync[1];
  assign supplyOk       = pinSync[2];
  assign batteryPresent = pinSync[3];

  // bus is dead until the supply conditions hold
  assign wrOk     = regWrStb & commEn_q;
  assign rdOk     = regRdStb & commEn_q;
  assign intClrWr = wrOk && (regAddr == REG_INT_STAT);

  // communication enable from the power-good comparators
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      commEn_q <= 1'b0;
    end else begin
      commEn_q <= adapterLowOk & supplyOk;
    end
  end

  // writable control registers; status writes fall through
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q    <= MODE_RST;
      chgV_q    <= CHGV_RST;
      intMask_q <= INTM_RST;
    end else if (wrOk) begin
      if (regAddr == REG_MODE) begin
        mode_q <= regWrData;
      end else if (regAddr == REG_CHGV) begin
        chgV_q <= regWrData;
      end else if (regAddr == REG_INT_MASK) begin
        intMask_q <= regWrData[INT_W-1:0];
      end
    end
  end

  // charge-voltage classification on the raw setting
  assign isWake      = (chgV_q == V_WAKE);
  assign inLoBand    = (chgV_q >= V_LO_MIN) && (chgV_q <= V_LO_MAX);
  assign inHiBand    = (chgV_q >= V_HI_MIN) && (chgV_q <= V_HI_MAX);
  assign aboveMax    = (chgV_q > V_HI_MAX);
  assign rangeBad    = !(isWake | inLoBand | inHiBand);
  assign rangeBlocks = rangeBad & ~aboveMax;
  assign fourCells   = inHiBand | aboveMax;
  // round down so a partial step never overshoots the pack
  assign roundedV    = chgV_q & ~V_STEP_MASK;

  // regulation target selection
  always_comb begin
    if (isWake) begin
      target_d = V_WAKE;
    end else if (aboveMax) begin
      target_d = V_HI_MAX;
    end else if (inLoBand | inHiBand) begin
      target_d = roundedV;
    end else begin
      target_d = 16'h0000;
    end
  end

  // depleted threshold: per-cell code scaled by cell count
  assign depCode     = mode_q[MODE_DEP_LSB +: MODE_DEP_W];
  assign perCellMv   = 16'(DEP_BASE_MV + 16'(DEP_STEP_MV * 16'(depCode)));
  assign depThreshMv = fourCells ? 16'(perCellMv << 2)
                                 : 16'(perCellMv + 16'(perCellMv << 1));
  assign depleted    = (batteryMv < depThreshMv);
  assign learnCycle  = mode_q[MODE_LEARN_BIT];

  // flag vector, low bit is the depleted flag
  assign flags_d = {adapterPresent,
                    batteryPresent,
                    (batteryMv > adapterMv),
                    rangeBad,
                    depleted};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // flags sit in the top bits, lower bits read zero
  assign statusWord = {flags_q, {(16 - STAT_FLAG_W){1'b0}}};

  // bypass margins, widened so the sum cannot wrap
  assign battPlusTrip    = {1'b0, batteryMv} + BYP_TRIP_MV;
  assign battPlusRecover = battPlusTrip + BYP_HYST_MV;
  assign bypassTrip      = ({1'b0, adapterMv} < battPlusTrip);
  assign bypassRecover   = ({1'b0, adapterMv} >= battPlusRecover);

  // bypass switch: instant off, deglitched on
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bypassOn_q    <= 1'b0;
      deglitchCnt_q <= '0;
    end else if (bypassTrip) begin
      bypassOn_q    <= 1'b0;
      deglitchCnt_q <= '0;
    end else if (!bypassOn_q && bypassRecover) begin
      if (deglitchCnt_q == CNT_W'(DEGLITCH_CYC - 1)) begin
        bypassOn_q    <= 1'b1;
        deglitchCnt_q <= '0;
      end else begin
        deglitchCnt_q <= deglitchCnt_q + 1'b1;
      end
    end else begin
      // any dip inside the hysteresis band restarts the wait
      deglitchCnt_q <= '0;
    end
  end

  // power-path switches
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      battDrv_q <= 1'b1;
      adDrv_q   <= 1'b0;
    end else if (!adapterPresent) begin
      battDrv_q <= 1'b1;
      adDrv_q   <= 1'b0;
    end else if (learnCycle) begin
      battDrv_q <= ~depleted;
      adDrv_q   <= depleted;
    end else begin
      battDrv_q <= 1'b0;
      adDrv_q   <= 1'b1;
    end
  end

  // charge gating and regulation target
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      chgEn_q  <= 1'b0;
      target_q <= 16'h0000;
      vrefEn_q <= 1'b0;
    end else begin
      // no host round trip: a removed pack stops charge next edge
      chgEn_q  <= adapterPresent & batteryPresent & ~rangeBlocks;
      target_q <= target_d;
      vrefEn_q <= adapterPresent;
    end
  end

  // alert delay timer, started by the first flag change
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      alertPend_q <= 1'b0;
      alertCnt_q  <= '0;
    end else if (alertPend_q) begin
      if (alertCnt_q == CNT_W'(ALERT_CYC - 1)) begin
        alertPend_q <= 1'b0;
        alertCnt_q  <= '0;
      end else begin
        alertCnt_q <= alertCnt_q + 1'b1;
      end
    end else if (flags_d != flags_q) begin
      alertPend_q <= 1'b1;
      alertCnt_q  <= '0;
    end
  end

  // alert stays high until the host reads status
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      alert_q <= 1'b0;
    end else if (alertPend_q && (alertCnt_q == CNT_W'(ALERT_CYC - 1))) begin
      alert_q <= 1'b1;
    end else if (rdOk && (regAddr == REG_STATUS)) begin
      alert_q <= 1'b0;
    end
  end

  // sticky interrupt events; a set in the clear cycle wins
  always_comb begin
    intStat_d = intStat_q;
    if (intClrWr) begin
      intStat_d = intStat_q & ~regWrData[INT_W-1:0];
    end
    if (flags_d != flags_q) begin
      intStat_d[INT_FLAG_CHG] = 1'b1;
    end
    if (rangeBlocks && !rangeBadPrev_q) begin
      intStat_d[INT_RANGE] = 1'b1;
    end
    if (bypassOn_q && bypassTrip) begin
      intStat_d[INT_BYPASS] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      intStat_q      <= '0;
      rangeBadPrev_q <= 1'b1; // reset setting is blocking: no false edge
    end else begin
      intStat_q      <= intStat_d;
      rangeBadPrev_q <= rangeBlocks;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_q <= '0;
    end else if (rdOk) begin
      if (regAddr == REG_MODE) begin
        rdData_q <= mode_q;
      end else if (regAddr == REG_STATUS) begin
        rdData_q <= statusWord;
      end else if (regAddr == REG_CHGV) begin
        rdData_q <= chgV_q;
      end else if (regAddr == REG_INT_STAT) begin
        rdData_q <= {{(DATA_W - INT_W){1'b0}}, intStat_q};
      end else if (regAddr == REG_INT_MASK) begin
        rdData_q <= {{(DATA_W - INT_W){1'b0}}, intMask_q};
      end else begin
        rdData_q <= '0;
      end
    end else begin
      rdData_q <= '0;
    end
  end

  // output drive
  assign regRdData          = rdData_q;
  assign batterySwitchDrive = battDrv_q;
  assign adapterSwitchDrive = adDrv_q;
  assign bypassSwitchDrive  = bypassOn_q;
  assign chargeEnable       = chgEn_q;
  assign regulationTargetMv = target_q;
  assign fiveVoltRefEnable  = vrefEn_q;
  assign commEnable         = commEn_q;
  assign alert              = alert_q;
  assign irq                = |(intStat_q & intMask_q);

endmodule

`default_nettype wire

// ===== tb/csfl_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// port-level watch on the flag logic; sees only the top ports
module csfl_asserts
  import csfl_pkg::*;
(
  input wire logic                        mclk,
  input wire logic                        reset_n,
  input wire logic                        regRdStb,
  input wire logic [csfl_pkg::DATA_W-1:0] regRdData,
  input wire logic                        commEnable,
  input wire logic                        adapterDetectLowPin,
  input wire logic                        supplyOkPin,
  input wire logic [15:0]                 batteryMv,
  input wire logic [15:0]                 adapterMv,
  input wire logic                        batterySwitchDrive,
  input wire logic                        adapterSwitchDrive,
  input wire logic                        bypassSwitchDrive,
  input wire logic                        chargeEnable,
  input wire logic                        fiveVoltRefEnable,
  input wire logic [15:0]                 regulationTargetMv
);
  // one domain, so clock and reset are given once
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_read_idle: assert property (!regRdStb |=> regRdData == 16'h0000)
    else $error("read data not zero outside read slot");
  a_read_refused: assert property (regRdStb && !commEnable |=> regRdData == 16'h0000)
    else $error("read answered before port enabled");
  a_comm_pins: assert property ($rose(commEnable) |-> $past(adapterDetectLowPin, 3) && $past(supplyOkPin, 3))
    else $error("port enabled without power good");
  a_switch_excl: assert property (!(batterySwitchDrive && adapterSwitchDrive))
    else $error("both path switches on");
  a_bypass_trip: assert property (({1'b0, adapterMv} < {1'b0, batteryMv} + BYP_TRIP_MV) |=> !bypassSwitchDrive)
    else $error("bypass not dropped on low margin");
  a_target_max: assert property (regulationTargetMv <= V_HI_MAX)
    else $error("target above maximum");
  a_target_step: assert property (regulationTargetMv == V_WAKE || regulationTargetMv[3:0] == 4'h0)
    else $error("target not on a converter step");
  a_charge_target: assert property (chargeEnable |-> regulationTargetMv != 16'h0000)
    else $error("charging with blocked setting");
  a_charge_ref: assert property (chargeEnable |-> fiveVoltRefEnable)
    else $error("charging without adapter");
endmodule

`default_nettype wire

// ===== tb/csfl_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the register port; strobes last one cycle
module csfl_host_model
  import csfl_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic [csfl_pkg::DATA_W-1:0] regRdData,
  output logic      [csfl_pkg::ADDR_W-1:0] regAddr,
  output logic      [csfl_pkg::DATA_W-1:0] regWrData,
  output logic                             regWrStb,
  output logic                             regRdStb
);
  // idle bus from time zero
  initial begin
    regAddr = 8'h00;
    regWrData = 16'h0000;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
  end

  // write: strobe beside address and data for one edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge mclk);
    regWrStb  <= 1'b0;
  endtask

  // read: data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge mclk);
    regRdStb <= 1'b0;
    #1;
    d = regRdData;
  endtask
endmodule

`default_nettype wire

// ===== tb/charger_status_flag_logic_test.sv
`timescale 1ns/1ps
`default_nettype none

module charger_status_flag_logic_test;
  import csfl_pkg::*;
  // short counts keep the run brief
  localparam int DCYC = 16;
  localparam int ACYC = 16;
  localparam logic [15:0] CV_IN [5] = '{16'h2ee5, 16'h3a98, 16'h4e20, 16'h2710, 16'h3840};
  localparam logic [15:0] CV_TG [5] = '{16'h2ee0, 16'h0000, 16'h4b00, 16'h0000, 16'h3840};
  localparam logic [4:0]  CV_FL     = 5'b01110;
  logic        mclk, reset_n, regWrStb, regRdStb, adDet, adDetLow, supOk, therm;
  logic [7:0]  regAddr;
  logic [15:0] regWrData, regRdData, batteryMv, adapterMv, target, rv;
  logic        batSw, adSw, bypSw, chgEn, refEn, commEnable, alert, irq;
  int          failures, n_checks;

  csfl_top #(.DEGLITCH_CYC(DCYC), .ALERT_CYC(ACYC)) uut (
    .mclk(mclk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .batteryMv(batteryMv), .adapterMv(adapterMv), .adapterDetectPin(adDet),
    .adapterDetectLowPin(adDetLow), .supplyOkPin(supOk), .thermistorBelowPin(therm),
    .batterySwitchDrive(batSw), .adapterSwitchDrive(adSw), .bypassSwitchDrive(bypSw),
    .chargeEnable(chgEn), .regulationTargetMv(target), .fiveVoltRefEnable(refEn),
    .commEnable(commEnable), .alert(alert), .irq(irq));

  csfl_host_model host (.mclk(mclk), .regRdData(regRdData), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb));

  // free-running clock, 4 ns
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    host.rd(a, rv);
    chk(rv & m, e);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard: a run this long counts as a mismatch
  initial begin
    cyc(20000);
    failures++;
    report_and_stop();
  end

  // main sequence
  initial begin
    logic [15:0] thr;
    int i;
    failures = 0;
    n_checks = 0;
    reset_n = 1'b0;
    adDetLow = 1'b1;
    supOk = 1'b1;
    adDet = 1'b0;
    therm = 1'b0;
    batteryMv = 16'h2ee0;
    adapterMv = 16'h4e20;
    cyc(4);
    chk({15'h0, batSw}, 16'h0001);
    chk({15'h0, commEnable}, 16'h0000);
    reset_n <= 1'b1;
    rdchk(REG_STATUS, 16'hffff, 16'h0000);
    for (i = 0; i < 50 && commEnable !== 1'b1; i++) cyc(1);
    if (commEnable !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    chk({14'h0, chgEn, refEn}, 16'h0000);
    // adapter and battery arrive, wake-up setting
    adDet <= 1'b1;
    therm <= 1'b1;
    host.wr(REG_CHGV, V_WAKE);
    cyc(5);
    chk(target, V_WAKE);
    chk({14'h0, chgEn, refEn}, 16'h0003);
    rdchk(REG_STATUS, 16'hffff, 16'hc000);
    rdchk(REG_CHGV, 16'hffff, V_WAKE);
    host.wr(REG_STATUS, 16'hffff);
    rdchk(REG_STATUS, 16'hffff, 16'hc000);
    rdchk(8'h20, 16'hffff, 16'h0000);
    // setting table: step, gap, above max, low, band top
    for (i = 0; i < 5; i++) begin
      host.wr(REG_CHGV, CV_IN[i]);
      cyc(3);
      chk(target, CV_TG[i]);
      chk({15'h0, chgEn}, {15'h0, !CV_FL[i] || i == 2});
      rdchk(REG_STATUS, 16'h1000, {3'h0, CV_FL[i], 12'h000});
    end
    // range-error interrupt: masked, unmasked, cleared
    host.wr(REG_CHGV, 16'h2ee0);
    host.wr(REG_INT_STAT, 16'h0007);
    rdchk(REG_INT_STAT, 16'h0002, 16'h0000);
    host.wr(REG_CHGV, 16'h3a98);
    cyc(3);
    rdchk(REG_INT_STAT, 16'h0002, 16'h0002);
    chk({15'h0, irq}, 16'h0000);
    host.wr(REG_INT_MASK, 16'h0002);
    cyc(1);
    chk({15'h0, irq}, 16'h0001);
    rdchk(REG_INT_MASK, 16'hffff, 16'h0002);
    host.wr(REG_INT_STAT, 16'h0002);
    cyc(1);
    chk({15'h0, irq}, 16'h0000);
    // depleted threshold: two codes, both bands, either side of it
    for (i = 0; i < 8; i++) begin
      host.wr(REG_MODE, {4'h0, i[1] ? 3'h7 : 3'h0, 9'h010});
      host.wr(REG_CHGV, i[2] ? 16'h3e80 : 16'h2ee0);
      thr = (DEP_BASE_MV + (i[1] ? 16'h0007 : 16'h0000) * DEP_STEP_MV) * (i[2] ? 16'h0004 : 16'h0003);
      batteryMv <= thr - {15'h0, i[0]};
      cyc(4);
      rdchk(REG_STATUS, 16'h0800, {4'h0, i[0], 11'h000});
      chk({14'h0, batSw, adSw}, i[0] ? 16'h0001 : 16'h0002);
      rdchk(REG_MODE, 16'h0e10, {4'h0, i[1] ? 3'h7 : 3'h0, 9'h010});
    end
    host.wr(REG_MODE, MODE_RST);
    cyc(2);
    chk({14'h0, batSw, adSw}, 16'h0001);
    // bypass: trip, hysteresis band, deglitch, reversal
    batteryMv <= 16'h2ee0;
    cyc(2);
    chk({15'h0, bypSw}, 16'h0001);
    adapterMv <= 16'h2f44;
    cyc(3);
    chk({15'h0, bypSw}, 16'h0000);
    adapterMv <= 16'h2fa8;
    cyc(30);
    chk({15'h0, bypSw}, 16'h0000);
    adapterMv <= 16'h300c;
    cyc(8);
    chk({15'h0, bypSw}, 16'h0000);
    cyc(17);
    chk({15'h0, bypSw}, 16'h0001);
    adapterMv <= 16'h2edf;
    cyc(4);
    rdchk(REG_STATUS, 16'h2000, 16'h2000);
    chk({15'h0, bypSw}, 16'h0000);
    // battery pulled: charging stops without the host
    host.wr(REG_CHGV, 16'h2ee0);
    adapterMv <= 16'h4e20;
    therm <= 1'b0;
    cyc(4);
    chk({15'h0, chgEn}, 16'h0000);
    rdchk(REG_STATUS, 16'h4000, 16'h0000);
    // alert delay after a flag change
    cyc(40);
    host.rd(REG_STATUS, rv);
    chk({15'h0, alert}, 16'h0000);
    therm <= 1'b1;
    cyc(8);
    chk({15'h0, alert}, 16'h0000);
    cyc(20);
    chk({15'h0, alert}, 16'h0001);
    report_and_stop();
  end
endmodule

bind csfl_top csfl_asserts chk_flags (
  .mclk(mclk), .reset_n(reset_n), .regRdStb(regRdStb), .regRdData(regRdData),
  .commEnable(commEnable), .adapterDetectLowPin(adapterDetectLowPin), .supplyOkPin(supplyOkPin),
  .batteryMv(batteryMv), .adapterMv(adapterMv), .batterySwitchDrive(batterySwitchDrive),
  .adapterSwitchDrive(adapterSwitchDrive), .bypassSwitchDrive(bypassSwitchDrive),
  .chargeEnable(chargeEnable), .fiveVoltRefEnable(fiveVoltRefEnable),
  .regulationTargetMv(regulationTargetMv));

`default_nettype wire
